/* File: iqc_collector.sv */
// interrupt request collector: synchronises peripheral requests, merges software-forced
// requests and presents them to the core interrupt inputs with fixed or shortest latency
// assumes peripheral requests are levels synchronous to aclk and an AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
`include "iqc_map.svh"

// Contract
// - synchronise peripheral requests onto 32 core lines
// - peripheral and software requests always merged on each line, no mode switch
// - writing one to clear bit sets request
// - writing one to set bit withdraws only its software request; a peripheral request stays
// - writing zero leaves bit unchanged
// - fast bit low: exactly 13 cycles latency
// - fast bit high: shortest latency
// - source and control read zero after reset
module iqc_collector #(
	parameter int FIXED_LAT = `IQC_FIXED_LAT
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// peripheral requests and core interrupt inputs
	input wire logic [31:0] periph_irq,
	output logic [31:0] core_interrupt_inputs,
	// summary interrupt
	output logic irq_out,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [`IQC_ADDR_W-1:0] awaddr,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [`IQC_ADDR_W-1:0] araddr,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);

	logic [31:0] sync1_reg, sync2_reg, src_reg, line_vec, line_prev_reg, rise;
	logic [31:0] stat_reg, mask_reg, core_reg, dly_out, wmask, smask;
	logic fast_reg, irq_reg, wr_go;
	logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
	logic [1:0] bresp_reg, rresp_reg;
	logic [31:0] rdata_reg, wdata_q;
	logic [3:0] wstrb_q;
	logic [`IQC_ADDR_W-1:0] awaddr_q;
	iqc_pkg::iqc_sel_t wr_sel;
	logic [4:0] fixed_run;

	// address decode, shared by both channels
	function automatic iqc_pkg::iqc_sel_t decode(input logic [`IQC_ADDR_W-1:0] a);
		logic [`IQC_ADDR_W-1:0] w;
		w = {a[`IQC_ADDR_W-1:2], 2'h0};
		case (w)
			`IQC_OFF_SRC: decode = iqc_pkg::IQC_SEL_SRC;
			`IQC_OFF_CTRL: decode = iqc_pkg::IQC_SEL_CTRL;
			`IQC_OFF_STAT: decode = iqc_pkg::IQC_SEL_STAT;
			`IQC_OFF_MASK: decode = iqc_pkg::IQC_SEL_MASK;
			default: decode = iqc_pkg::IQC_SEL_NONE;
		endcase
	endfunction

	// byte strobes widened to a bit mask
	function automatic logic [31:0] strb_mask(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++)
			m[i*8 +: 8] = {8{s[i]}};
		return m;
	endfunction

	// two-stage synchroniser; only the second stage feeds the merge
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1_reg <= `IQC_RST_WORD;
			sync2_reg <= `IQC_RST_WORD;
		end
		else if (ce)
		begin
			sync1_reg <= periph_irq;
			sync2_reg <= sync1_reg;
		end
	end

	// a line is up for either a peripheral or a software request
	assign line_vec = sync2_reg | src_reg;
	assign rise = line_vec & ~line_prev_reg;
	assign smask = strb_mask(wstrb_q);
	assign wmask = wdata_q & smask;
	assign wr_sel = decode(awaddr_q);
	assign wr_go = !awready_reg && !wready_reg && !bvalid_reg;

	// fixed path: the delay line plus the output flop make the full latency
	iqc_delay_line #(
		.DEPTH(FIXED_LAT - 1),
		.W(32)
	) u_delay (
		.aclk(aclk),
		.aresetn(aresetn),
		.ce(ce),
		.din(line_vec),
		.dout(dly_out)
	);

	// core line driver; a mode change mid-flight may drop or repeat a short pulse
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			core_reg <= `IQC_RST_WORD;
		else if (ce)
			core_reg <= fast_reg ? line_vec : dly_out;
	end

	// write address channel, held until the write commits
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready_reg <= 1'h1;
			awaddr_q <= '0;
		end
		else if (ce)
		begin
			if (awvalid && awready_reg)
			begin
				awready_reg <= 1'h0;
				awaddr_q <= awaddr;
			end
			else if (wr_go)
				awready_reg <= 1'h1;
		end
	end

	// write data channel, taken independently of the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			wready_reg <= 1'h1;
			wdata_q <= `IQC_RST_WORD;
			wstrb_q <= 4'h0;
		end
		else if (ce)
		begin
			if (wvalid && wready_reg)
			begin
				wready_reg <= 1'h0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			else if (wr_go)
				wready_reg <= 1'h1;
		end
	end

	// write response; unmapped addresses answer with a slave error
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_reg <= 1'h0;
			bresp_reg <= `IQC_RESP_OKAY;
		end
		else if (ce)
		begin
			if (wr_go)
			begin
				bvalid_reg <= 1'h1;
				bresp_reg <= (wr_sel == iqc_pkg::IQC_SEL_NONE) ? `IQC_RESP_SLVERR : `IQC_RESP_OKAY;
			end
			else if (bready)
				bvalid_reg <= 1'h0;
		end
	end

	// source bits: a one clears a raised line's software part, else sets it
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			src_reg <= `IQC_RST_WORD;
		else if (ce && wr_go && wr_sel == iqc_pkg::IQC_SEL_SRC)
			src_reg <= (src_reg & ~wmask) | (wmask & ~line_vec);
	end

	// low-latency enable
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			fast_reg <= `IQC_RST_BIT;
		else if (ce && wr_go && wr_sel == iqc_pkg::IQC_SEL_CTRL && wstrb_q[0])
			fast_reg <= wdata_q[`IQC_FAST_BIT];
	end

	// sticky line-rise status; a rise in the clearing cycle wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat_reg <= `IQC_RST_WORD;
			line_prev_reg <= `IQC_RST_WORD;
		end
		else if (ce)
		begin
			line_prev_reg <= line_vec;
			if (wr_go && wr_sel == iqc_pkg::IQC_SEL_STAT)
				stat_reg <= (stat_reg & ~wmask) | rise;
			else
				stat_reg <= stat_reg | rise;
		end
	end

	// mask, byte-lane writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mask_reg <= `IQC_RST_WORD;
		else if (ce && wr_go && wr_sel == iqc_pkg::IQC_SEL_MASK)
			mask_reg <= (mask_reg & ~smask) | (wdata_q & smask);
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			irq_reg <= 1'h0;
		else if (ce)
			irq_reg <= |(stat_reg & mask_reg);
	end

	// read channel: data one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_reg <= 1'h1;
			rvalid_reg <= 1'h0;
			rdata_reg <= `IQC_RST_WORD;
			rresp_reg <= `IQC_RESP_OKAY;
		end
		else if (ce)
		begin
			if (arvalid && arready_reg)
			begin
				arready_reg <= 1'h0;
				rvalid_reg <= 1'h1;
				rresp_reg <= `IQC_RESP_OKAY;
				case (decode(araddr))
					iqc_pkg::IQC_SEL_SRC: rdata_reg <= line_vec;
					iqc_pkg::IQC_SEL_CTRL: rdata_reg <= {31'h0, fast_reg};
					iqc_pkg::IQC_SEL_STAT: rdata_reg <= stat_reg;
					iqc_pkg::IQC_SEL_MASK: rdata_reg <= mask_reg;
					default:
					begin
						rdata_reg <= `IQC_RST_WORD;
						rresp_reg <= `IQC_RESP_SLVERR;
					end
				endcase
			end
			else if (rvalid_reg && rready)
			begin
				rvalid_reg <= 1'h0;
				arready_reg <= 1'h1;
			end
		end
	end

	// outputs straight from flops
	assign core_interrupt_inputs = core_reg;
	assign irq_out = irq_reg;
	assign awready = awready_reg;
	assign wready = wready_reg;
	assign bvalid = bvalid_reg;
	assign bresp = bresp_reg;
	assign arready = arready_reg;
	assign rvalid = rvalid_reg;
	assign rdata = rdata_reg;
	assign rresp = rresp_reg;

	// helper: cycles spent enabled in fixed mode, saturating
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ce || fast_reg)
			fixed_run <= 5'h00;
		else if (fixed_run != 5'h1f)
			fixed_run <= fixed_run + 5'h01;
	end

	a_fixed_latency: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(fixed_run > 5'(FIXED_LAT)) |-> (core_reg == $past(line_vec, FIXED_LAT)))
		else $error("fixed latency path not exact");

	a_fast_latency: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		($past(fast_reg) && $past(ce) && $past(aresetn)) |-> (core_reg == $past(line_vec)))
		else $error("fast path not one cycle");

	a_sync_path: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		($past(fast_reg) && $past(src_reg) == 32'h0 && $past(ce) && $past(ce, 2) && $past(ce, 3)
		&& $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3))
		|-> (core_reg == $past(periph_irq, 3)))
		else $error("peripheral request not synchronised");

	a_src_toggle: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(wr_go && wr_sel == iqc_pkg::IQC_SEL_SRC) |=>
		((src_reg & $past(wmask)) == ($past(wmask) & ~$past(line_vec))))
		else $error("source bit write one wrong");

	a_zero_keeps: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(wr_go && wr_sel == iqc_pkg::IQC_SEL_SRC) |=>
		((src_reg & ~$past(wmask)) == ($past(src_reg) & ~$past(wmask))))
		else $error("source bit changed on zero");

	a_reset_zero: assert property (@(posedge aclk)
		!aresetn |=> (src_reg == 32'h0 && !fast_reg && !bvalid_reg && !rvalid_reg))
		else $error("reset values not zero");

	a_src_read: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(arvalid && arready_reg && decode(araddr) == iqc_pkg::IQC_SEL_SRC) |=>
		(rvalid_reg && rdata_reg == $past(line_vec) && rresp_reg == `IQC_RESP_OKAY))
		else $error("source read not line state");

	a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(wr_go && wr_sel == iqc_pkg::IQC_SEL_STAT) |=> ((stat_reg & $past(rise)) == $past(rise)))
		else $error("status rise lost under clear");

	a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		($past(ce) && $past(aresetn)) |-> (irq_reg == |($past(stat_reg) & $past(mask_reg))))
		else $error("interrupt output wrong");

	a_bad_write: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(wr_go && wr_sel == iqc_pkg::IQC_SEL_NONE) |=> (bvalid_reg && bresp_reg == `IQC_RESP_SLVERR))
		else $error("unmapped write not refused");

endmodule // iqc_collector

`default_nettype wire

/* File: iqc_collector_tb.sv */
// self-checking bench for the interrupt request collector
// assumes the collector and the peripheral source model in the same folder
`timescale 1ns/1ps
`default_nettype none
`include "iqc_map.svh"

module iqc_collector_tb;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} iqc_row_t;
	// clock, reset and bus signals
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irq_out;
	logic [7:0] awaddr, araddr;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] wdata, rdata, req, periph_irq, core_interrupt_inputs, rd, sw_exp;
	int mismatches, cmp_count, n;
	// address, write data, expected read-back
	iqc_row_t rows [8] = '{
		'{`IQC_OFF_SRC, 32'h0000_0001, 32'h0000_0001},
		'{`IQC_OFF_SRC, 32'h0000_0000, 32'h0000_0001},
		'{`IQC_OFF_SRC, 32'h8000_0003, 32'h8000_0002},
		'{`IQC_OFF_SRC, 32'h8000_0002, 32'h0000_0000},
		'{`IQC_OFF_CTRL, 32'hffff_ffff, 32'h0000_0001},
		'{`IQC_OFF_CTRL, 32'h0000_0000, 32'h0000_0000},
		'{`IQC_OFF_MASK, 32'h0000_00a5, 32'h0000_00a5},
		'{`IQC_OFF_MASK, 32'h0000_0000, 32'h0000_0000}};

	iqc_periph_model peri (.aclk(aclk), .aresetn(aresetn), .req(req), .periph_irq(periph_irq));

	iqc_collector #(.FIXED_LAT(`IQC_FIXED_LAT)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.periph_irq(periph_irq), .core_interrupt_inputs(core_interrupt_inputs), .irq_out(irq_out),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));

	// 200 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t ns: seen %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// address and data offered together, each dropped on its own handshake
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad = 1'b0;
		bit wd = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			ad = ad | awready;
			wd = wd | wready;
		end
		while (!bvalid) @(posedge aclk);
		rsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rdw(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(posedge aclk);
		while (!arready) @(posedge aclk);
		arvalid <= 1'b0;
		@(posedge aclk);
		while (!rvalid) @(posedge aclk);
		rd = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask

	// edges from launching a peripheral request until core line 4 rises
	task automatic lat(input logic fast, input int exp_n);
		wr(`IQC_OFF_CTRL, {31'h0, fast});
		repeat (20) @(posedge aclk);
		req <= 32'h0000_0010;
		n = 0;
		while (!core_interrupt_inputs[4] && n < 40)
		begin
			@(posedge aclk);
			n++;
			#1;
		end
		chk(n, exp_n);
		req <= 32'h0000_0000;
		repeat (20) @(posedge aclk);
	endtask

	// hang guard, well beyond the roughly 400 cycles the sequence needs
	initial
	begin
		repeat (3000) @(posedge aclk);
		mismatches++;
		stop_test();
	end

	// main sequence
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, req, sw_exp} = 112'h0;
		ce = 1'b1;
		wstrb = 4'hf;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			chk(rsp, `IQC_RESP_OKAY);
			rdw(rows[i].a);
			chk(rsp, `IQC_RESP_OKAY);
			chk(rd, rows[i].e);
			if (rows[i].a == `IQC_OFF_SRC) sw_exp = rows[i].e;
			repeat (16) @(posedge aclk);
			#1;
			chk(core_interrupt_inputs, sw_exp);
		end
		// latency in both modes; peripheral is sampled two edges after launch
		wr(`IQC_OFF_STAT, 32'hffff_ffff);
		wr(`IQC_OFF_MASK, 32'h0000_0010);
		lat(1'b0, 3 + `IQC_FIXED_LAT);
		lat(1'b1, 4);
		rdw(`IQC_OFF_STAT);
		chk(rd, 32'h0000_0010);
		chk(irq_out, 1'b1);
		wr(`IQC_OFF_STAT, 32'h0000_0010);
		rdw(`IQC_OFF_STAT);
		chk(rd, 32'h0000_0000);
		chk(irq_out, 1'b0);
		// masked event stays off the summary line; software cannot drop a peripheral line
		req <= 32'h0000_0020;
		repeat (10) @(posedge aclk);
		rdw(`IQC_OFF_STAT);
		chk(rd, 32'h0000_0020);
		chk(irq_out, 1'b0);
		wr(`IQC_OFF_SRC, 32'h0000_0020);
		rdw(`IQC_OFF_SRC);
		chk(rd, 32'h0000_0020);
		wr(`IQC_OFF_SRC, 32'h0000_0001);
		rdw(`IQC_OFF_SRC);
		chk(rd, 32'h0000_0021);
		#1;
		chk(core_interrupt_inputs, 32'h0000_0021);
		// unmapped word refuses both directions
		wr(8'h40, 32'hffff_ffff);
		chk(rsp, `IQC_RESP_SLVERR);
		rdw(8'h40);
		chk(rsp, `IQC_RESP_SLVERR);
		chk(rd, 32'h0000_0000);
		// clock enable low freezes every flop except the helper counters, which clear, while the peripheral side moves on
		ce <= 1'b0;
		req <= 32'h0000_0000;
		repeat (10) @(posedge aclk);
		#1;
		chk(core_interrupt_inputs, 32'h0000_0021);
		@(posedge aclk);
		ce <= 1'b1;
		repeat (5) @(posedge aclk);
		#1;
		chk(core_interrupt_inputs, 32'h0000_0001);
		// second reset in mid-run with a software bit still set
		req <= 32'h0000_0000;
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		#1;
		chk(core_interrupt_inputs, 32'h0000_0000);
		chk({awready, wready, arready, bvalid, rvalid, irq_out}, 6'h38);
		rdw(`IQC_OFF_SRC);
		chk(rd, `IQC_RST_WORD);
		rdw(`IQC_OFF_CTRL);
		chk(rd, `IQC_RST_WORD);
		stop_test();
	end
endmodule // iqc_collector_tb

`default_nettype wire

/* File: iqc_delay_line.sv */
// shift-register delay line for a vector of request lines
// assumes one clock, synchronous active-low reset and a freezing clock enable
`timescale 1ns/1ps
`default_nettype none
`include "iqc_map.svh"

module iqc_delay_line #(
	parameter int DEPTH = `IQC_FIXED_LAT - 1,
	parameter int W = 32
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	localparam int RUN_W = $clog2(DEPTH + 1);

	logic [W-1:0] stage [DEPTH];
	logic [RUN_W-1:0] run_cnt;

	// one stage per cycle; an array keeps the depth a single parameter
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < DEPTH; i++)
				stage[i] <= '0;
		end
		else if (ce)
		begin
			stage[0] <= din;
			for (int i = 1; i < DEPTH; i++)
				stage[i] <= stage[i-1];
		end
	end

	assign dout = stage[DEPTH-1];

	// helper: enabled edges in a row out of reset; a reset or freeze mid-line breaks the relation
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !ce)
			run_cnt <= '0;
		else if (run_cnt != RUN_W'(DEPTH))
			run_cnt <= run_cnt + RUN_W'(1);
	end

	a_delay_depth: assert property (@(posedge aclk) disable iff (!aresetn || !ce)
		(run_cnt == RUN_W'(DEPTH)) |-> (dout == $past(din, DEPTH)))
		else $error("delay line depth wrong");

endmodule // iqc_delay_line

`default_nettype wire

/* File: iqc_map.svh */
// register offsets, field positions, reset values and timing counts of the collector
// assumes byte addresses on a 32-bit AXI4-Lite slave, one aligned word per register
`ifndef IQC_MAP_SVH
`define IQC_MAP_SVH

// address width decoded by the slave
`define IQC_ADDR_W 8
// register byte offsets
`define IQC_OFF_SRC 8'h84
`define IQC_OFF_CTRL 8'h88
`define IQC_OFF_STAT 8'h8c
`define IQC_OFF_MASK 8'h90
// low-latency enable bit in the control word
`define IQC_FAST_BIT 0
// reset values
`define IQC_RST_WORD 32'h0000_0000
`define IQC_RST_BIT 1'h0
// fixed latency in system clock cycles
`define IQC_FIXED_LAT 13
// AXI responses
`define IQC_RESP_OKAY 2'h0
`define IQC_RESP_SLVERR 2'h2

`endif

/* File: iqc_periph_model.sv */
// peripheral request source standing in front of the collector
// assumes one clock and requests that are levels launched on the rising edge
`timescale 1ns/1ps
`default_nettype none

module iqc_periph_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// pattern asked for by the bench
	input wire logic [31:0] req,
	// level requests into the collector
	output logic [31:0] periph_irq
);
	// answers one cycle late, like a flag flop inside a real peripheral
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			periph_irq <= 32'h0000_0000;
		else
			periph_irq <= req;
	end
endmodule // iqc_periph_model

`default_nettype wire

/* File: iqc_pkg.sv */
// shared types of the interrupt request collector
// assumes iqc_map.svh for all numeric constants
`default_nettype none

package iqc_pkg;

	// register selected by an address
	typedef enum logic [2:0]
	{
		IQC_SEL_SRC,
		IQC_SEL_CTRL,
		IQC_SEL_STAT,
		IQC_SEL_MASK,
		IQC_SEL_NONE
	} iqc_sel_t;

endpackage

`default_nettype wire
